// file: design/arad_regfile.sv
// Auxiliary register file with registered read port for the bus.
// Assumes one clock; write port has priority over nothing else.
`timescale 1ns/1ps
module arad_regfile #(
    parameter int NUM_REGS = 8
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        wr_en,
    input  wire logic [2:0]  wr_sel,
    input  wire logic [15:0] wr_data,
    input  wire logic [2:0]  rd_sel,
    output logic [15:0]      rd_data,
    input  wire logic [2:0]  cur_sel,
    output logic [15:0]      cur_data
);
    logic [15:0] mem [NUM_REGS];

    // ****************************************************************
    // Storage
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    mem[gi] <= araddr_pkg::AUX_RESET;
                end else if (wr_en && (wr_sel == 3'(gi))) begin
                    mem[gi] <= wr_data;
                end
            end
        end
    endgenerate

    wire logic rd_ok  = 32'(rd_sel) < NUM_REGS;
    wire logic cur_ok = 32'(cur_sel) < NUM_REGS;

    // The current-register view is combinational so it tracks the pointer.
    assign cur_data = cur_ok ? mem[cur_sel] : 16'h0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_data <= 16'h0000;
        end else begin
            rd_data <= rd_ok ? mem[rd_sel] : 16'h0000;
        end
    end
endmodule

// file: design/arad_unit.sv
// Auxiliary register address unit: register file, pointer and buffer,
// auxiliary arithmetic, page pointer and data address generation.
// Assumes the instruction decoder drives one-cycle command strobes on aclk.
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
// Contract
// [RULE_01] The file holds eight 16-bit auxiliary registers, or five on the reduced variant.
// [RULE_02] A 3-bit pointer selects the active auxiliary register.
// [RULE_03] The auxiliary file bus always shows the register the pointer selects.
// [RULE_04] A dedicated 16-bit unsigned unit does all auxiliary register arithmetic.
// [RULE_05] Each pointer load copies the old pointer into the 3-bit pointer buffer.
// [RULE_06] A pointer load by the load-status instruction does not copy into the buffer.
// [RULE_07] Loading the second status register writes the buffer value into the pointer too.
// [RULE_08] A 9-bit page pointer names the current data memory page.
// [RULE_09] Pages are 128 words each, giving 512 pages.
// [RULE_10] The direct address is the page pointer above the seven low instruction bits.
// [RULE_11] Data addresses go to memory on a dedicated 16-bit address bus.
// [RULE_12] Auxiliary updates run every cycle alongside the central unit, never stalling.
// [RULE_13] Auxiliary registers exchange values over the shared 16-bit data bus.
// [RULE_14] Buffer capture and the new pointer load happen on the same clock edge.
module arad_unit #(
    parameter int NUM_REGS = araddr_pkg::FULL_REGS
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Instruction decoder side.
    input  wire logic [15:0] instr_word,
    input  wire logic        direct_mode,
    input  wire logic [2:0]  aux_op,
    input  wire logic [15:0] aux_index,
    input  wire logic        ptr_load,
    input  wire logic [2:0]  ptr_value,
    input  wire logic        load_status_instr,
    input  wire logic        load_status_second_instr,
    input  wire logic [2:0]  status_buf_value,
    input  wire logic        page_load,
    input  wire logic [8:0]  page_value,
    input  wire logic        data_bus_store,
    input  wire logic [15:0] data_bus_in,
    output logic [15:0]      data_bus_out,
    output logic [15:0]      aux_file_bus,
    output logic [15:0]      direct_address_bus,
    output logic [15:0]      data_address_bus,
    output logic [2:0]       aux_pointer,
    output logic [2:0]       aux_pointer_buffer,
    output logic [8:0]       page_pointer,
    // AXI4-Lite slave.
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    // ****************************************************************
    // AXI write channel capture
    // ****************************************************************
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;

    wire logic aw_take = s_axi_awvalid && s_axi_awready;
    wire logic w_take  = s_axi_wvalid && s_axi_wready;
    // Both halves of a write are held, so the write fires this cycle; decoder traffic to the same file, pointer or page drops it.
    wire logic wr_fire = aw_held && w_held;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (aw_take) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else if (w_take) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    // ****************************************************************
    // Write decode
    // ****************************************************************
    function automatic logic is_aux_addr(input logic [7:0] a);
        is_aux_addr = (a[7:5] == araddr_pkg::OFF_AUX_BASE[7:5]) && (a[1:0] == 2'h0)
                      && (32'(a[4:2]) < NUM_REGS);
    endfunction

    wire logic       wr_aux     = wr_fire && is_aux_addr(aw_addr);
    wire logic       wr_ptr     = wr_fire && (aw_addr == araddr_pkg::OFF_POINTER);
    wire logic       wr_page    = wr_fire && (aw_addr == araddr_pkg::OFF_PAGE);
    wire logic       wr_known   = is_aux_addr(aw_addr) || (aw_addr == araddr_pkg::OFF_POINTER)
                                  || (aw_addr == araddr_pkg::OFF_PAGE)
                                  || (aw_addr == araddr_pkg::OFF_BUS_VIEW);
    wire logic [2:0] wr_aux_sel = aw_addr[4:2];
    wire logic [15:0] wr_word   = {w_strb[1] ? w_data[15:8] : 8'h00,
                                   w_strb[0] ? w_data[7:0] : 8'h00};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= araddr_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? araddr_pkg::RESP_OKAY : araddr_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // Auxiliary arithmetic unit
    // ****************************************************************
    logic [15:0] arith_result;
    logic        arith_write;

    // Unsigned 16-bit arithmetic wraps modulo 2^16, apart from the main datapath. [RULE_04]
    always_comb begin
        arith_write  = 1'b1;
        case (araddr_pkg::arad_op_type'(aux_op))
            araddr_pkg::ARAD_OP_INC:     arith_result = aux_file_bus + 16'h0001;
            araddr_pkg::ARAD_OP_DEC:     arith_result = aux_file_bus - 16'h0001;
            araddr_pkg::ARAD_OP_ADD_IDX: arith_result = aux_file_bus + aux_index;
            araddr_pkg::ARAD_OP_SUB_IDX: arith_result = aux_file_bus - aux_index;
            araddr_pkg::ARAD_OP_LOAD:    arith_result = aux_index;
            default: begin
                arith_result = aux_file_bus;
                arith_write  = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // Register file write arbitration
    // ****************************************************************
    // Decoder traffic always wins so the core never waits on the bus. [RULE_12]
    wire logic        rf_wr_en   = data_bus_store || arith_write || wr_aux;
    wire logic [2:0]  rf_wr_sel  = (data_bus_store || arith_write) ? aux_pointer : wr_aux_sel;
    wire logic [15:0] rf_wr_data = data_bus_store ? data_bus_in :
                                   arith_write ? arith_result : wr_word; // [RULE_13]
    wire logic [2:0]  rf_rd_sel  = s_axi_araddr[4:2];
    logic [15:0]      rf_rd_data;

    // Eight or five registers by parameter. [RULE_01]
    arad_regfile #(
        .NUM_REGS (NUM_REGS)
    ) u_regfile (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .wr_en    (rf_wr_en),
        .wr_sel   (rf_wr_sel),
        .wr_data  (rf_wr_data),
        .rd_sel   (rf_rd_sel),
        .rd_data  (rf_rd_data),
        .cur_sel  (aux_pointer),
        .cur_data (aux_file_bus)
    );
    // The selected register is shown combinationally on the file bus. [RULE_03]

    // ****************************************************************
    // Pointer and pointer buffer
    // ****************************************************************
    wire logic       ptr_from_bus = wr_ptr && w_strb[0] && !ptr_load
                                    && !load_status_instr && !load_status_second_instr;
    wire logic       any_ptr_load = ptr_load || load_status_instr || ptr_from_bus;
    // Second status load puts the buffer value in both registers. [RULE_07]
    wire logic [2:0] next_aux_pointer =
        load_status_second_instr ? status_buf_value :
        (ptr_load || load_status_instr) ? ptr_value :
        ptr_from_bus ? w_data[araddr_pkg::PTR_LSB +: 3] : aux_pointer; // [RULE_02]
    wire logic [2:0] next_aux_pointer_buffer =
        load_status_second_instr ? status_buf_value :
        (any_ptr_load && !load_status_instr) ? aux_pointer : // [RULE_05] [RULE_06]
        aux_pointer_buffer;

    // Both registers update on one edge, so the buffer holds the prior pointer. [RULE_14]
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aux_pointer        <= araddr_pkg::PTR_RESET;
            aux_pointer_buffer <= araddr_pkg::PTR_RESET;
        end else begin
            aux_pointer        <= next_aux_pointer;
            aux_pointer_buffer <= next_aux_pointer_buffer;
        end
    end

    // ****************************************************************
    // Page pointer and address generation
    // ****************************************************************
    wire logic [8:0] next_page_pointer = page_load ? page_value :
        (wr_page && !page_load) ? w_data[8:0] : page_pointer;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            page_pointer <= araddr_pkg::PAGE_RESET; // [RULE_08]
        end else begin
            page_pointer <= next_page_pointer;
        end
    end

    // Page above 7-bit offset: 512 pages of 128 words. [RULE_09] [RULE_10]
    assign direct_address_bus = {page_pointer, instr_word[araddr_pkg::OFFS_W-1:0]};

    // The address bus is registered so memory sees a stable word. [RULE_11]
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_address_bus <= 16'h0000;
            data_bus_out     <= 16'h0000;
        end else begin
            data_address_bus <= direct_mode ? direct_address_bus : aux_file_bus;
            data_bus_out     <= aux_file_bus; // [RULE_13]
        end
    end

    // ****************************************************************
    // AXI read channel
    // ****************************************************************
    logic       rd_wait;
    logic [7:0] rd_addr;
    assign s_axi_arready = !s_axi_rvalid && !rd_wait;

    wire logic ar_take = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_wait <= 1'b0;
            rd_addr <= 8'h00;
        end else begin
            rd_wait <= ar_take;
            if (ar_take) begin
                rd_addr <= s_axi_araddr;
            end
        end
    end

    wire logic [31:0] rd_word =
        is_aux_addr(rd_addr) ? {16'h0000, rf_rd_data} :
        (rd_addr == araddr_pkg::OFF_POINTER) ?
            {21'h0, aux_pointer_buffer, 5'h00, aux_pointer} :
        (rd_addr == araddr_pkg::OFF_PAGE) ? {23'h0, page_pointer} :
        (rd_addr == araddr_pkg::OFF_BUS_VIEW) ? {16'h0000, aux_file_bus} : 32'h00000000;
    wire logic rd_known = is_aux_addr(rd_addr) || (rd_addr == araddr_pkg::OFF_POINTER)
                          || (rd_addr == araddr_pkg::OFF_PAGE)
                          || (rd_addr == araddr_pkg::OFF_BUS_VIEW);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= araddr_pkg::RESP_OKAY;
        end else if (rd_wait) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_known ? araddr_pkg::RESP_OKAY : araddr_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// file: design/araddr_pkg.sv
// Constants for the auxiliary register and data address unit.
// Assumes a single core clock and a synchronous active-low reset.
package araddr_pkg;
    // ****************************************************************
    // Widths and sizes
    // ****************************************************************
    localparam int        DATA_W        = 16;
    localparam int        PTR_W         = 3;
    localparam int        PAGE_W        = 9;
    localparam int        OFFS_W        = 7;
    localparam int        FULL_REGS     = 8;
    localparam int        REDUCED_REGS  = 5;
    localparam int        PAGE_WORDS    = 128;
    localparam int        PAGE_COUNT    = 512;
    // ****************************************************************
    // Register offsets (byte addresses on the AXI4-Lite bus)
    // ****************************************************************
    localparam logic [7:0] OFF_AUX_BASE  = 8'h00;
    localparam logic [7:0] OFF_POINTER   = 8'h20;
    localparam logic [7:0] OFF_PAGE      = 8'h24;
    localparam logic [7:0] OFF_BUS_VIEW  = 8'h28;
    // ****************************************************************
    // Field positions of the pointer register
    // ****************************************************************
    localparam int        PTR_LSB       = 0;
    localparam int        BUF_LSB       = 8;
    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [15:0] AUX_RESET   = 16'h0000;
    localparam logic [2:0]  PTR_RESET   = 3'h0;
    localparam logic [8:0]  PAGE_RESET  = 9'h000;
    // ****************************************************************
    // Auxiliary arithmetic operations
    // ****************************************************************
    typedef enum logic [2:0] {
        ARAD_OP_NONE,
        ARAD_OP_INC,
        ARAD_OP_DEC,
        ARAD_OP_ADD_IDX,
        ARAD_OP_SUB_IDX,
        ARAD_OP_LOAD
    } arad_op_type;
    // ****************************************************************
    // AXI responses
    // ****************************************************************
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: test/arad_mem_model.sv
// Data memory model answering the unit's data address bus.
// Assumes the address comes from the registered data address bus.
`timescale 1ns/1ps
module arad_mem_model (
    input  wire logic [15:0] addr,
    output logic [15:0]      rd_word
);
    // Each word holds its address byte above its inverse, so a wrong address shows.
    assign rd_word = {addr[7:0], ~addr[7:0]};
endmodule

// file: test/arad_unit_properties.sv
// Concurrent checks on the ports of the address unit.
// Assumes it is bound to arad_unit and sees its ports by name.
`timescale 1ns/1ps
module arad_unit_props #(
    parameter int NUM_REGS = 8
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [15:0] instr_word,
    input wire logic        direct_mode,
    input wire logic [2:0]  aux_op,
    input wire logic        ptr_load,
    input wire logic [2:0]  ptr_value,
    input wire logic        load_status_instr,
    input wire logic        load_status_second_instr,
    input wire logic [2:0]  status_buf_value,
    input wire logic        page_load,
    input wire logic [8:0]  page_value,
    input wire logic        data_bus_store,
    input wire logic [15:0] data_bus_in,
    input wire logic [15:0] aux_file_bus,
    input wire logic [15:0] direct_address_bus,
    input wire logic [15:0] data_address_bus,
    input wire logic [2:0]  aux_pointer,
    input wire logic [2:0]  aux_pointer_buffer,
    input wire logic [8:0]  page_pointer,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire quiet = !ptr_load && !load_status_instr && !load_status_second_instr;
    direct_addr_a: assert property (direct_address_bus == {page_pointer, instr_word[6:0]})
        else $error("direct address is not page and offset");
    page_load_a: assert property (page_load |=> page_pointer == $past(page_value))
        else $error("page pointer not loaded");
    buf_capture_a: assert property (ptr_load && !load_status_second_instr |=>
        aux_pointer_buffer == $past(aux_pointer) && aux_pointer == $past(ptr_value))
        else $error("pointer load did not buffer old pointer");
    status_keep_a: assert property (load_status_instr && !ptr_load && !load_status_second_instr
        |=> $stable(aux_pointer_buffer) && aux_pointer == $past(ptr_value))
        else $error("status load touched the buffer");
    second_load_a: assert property (load_status_second_instr |=> aux_pointer ==
        $past(status_buf_value) && aux_pointer_buffer == $past(status_buf_value))
        else $error("second status load did not set both");
    dab_direct_a: assert property (direct_mode |=> data_address_bus == $past(direct_address_bus))
        else $error("data address bus missed direct address");
    dab_aux_a: assert property (!direct_mode |=> data_address_bus == $past(aux_file_bus))
        else $error("data address bus missed aux file bus");
    aux_inc_a: assert property (aux_op == araddr_pkg::ARAD_OP_INC && !data_bus_store && quiet
        && aux_pointer < NUM_REGS |=> aux_file_bus == $past(aux_file_bus) + 16'h1)
        else $error("increment not applied");
    bus_store_a: assert property (data_bus_store && quiet && aux_pointer < NUM_REGS
        |=> aux_file_bus == $past(data_bus_in))
        else $error("data bus store not applied");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
endmodule
bind arad_unit arad_unit_props #(.NUM_REGS(NUM_REGS)) u_props (.*);

// file: test/aux_register_address_unit_tb.sv
// Self-checking bench for the auxiliary register address unit.
// Assumes the unit's default of eight registers and a 100 MHz clock.
`timescale 1ns/1ps
module aux_register_address_unit_tb;
    logic        aclk = 0, aresetn = 0, chk_on = 0;
    logic [15:0] instr_word, aux_index, data_bus_in, data_bus_out, aux_file_bus, mem_word;
    logic [15:0] direct_address_bus, data_address_bus, m_dab, m_dbo, afb;
    logic        direct_mode, ptr_load, load_status_instr, load_status_second_instr;
    logic        page_load, data_bus_store;
    logic [2:0]  aux_op, ptr_value, status_buf_value, aux_pointer, aux_pointer_buffer, m_ptr, m_buf;
    logic [8:0]  page_value, page_pointer, m_page;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [15:0] m_reg [8];
    int          n_errors = 0, comparisons = 0, cycles = 0, c;
    arad_unit u_dut (.*);
    arad_mem_model u_mem (.addr(data_address_bus), .rd_word(mem_word));
    initial forever #5 aclk = ~aclk;
    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task final_report;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // ****************************************************************
    // Reference model, stepped on every rising edge
    // ****************************************************************
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            final_report();
        end
        if (!aresetn) begin
            {m_ptr, m_buf, m_page, m_dab, m_dbo} = '0;
            foreach (m_reg[i]) m_reg[i] = 16'h0000;
        end else begin
            afb = m_reg[m_ptr];
            m_dab = direct_mode ? {m_page, instr_word[6:0]} : afb;
            m_dbo = afb;
            if (data_bus_store) m_reg[m_ptr] = data_bus_in;
            else case (aux_op)
                3'h1: m_reg[m_ptr] = afb + 16'h1;
                3'h2: m_reg[m_ptr] = afb - 16'h1;
                3'h3: m_reg[m_ptr] = afb + aux_index;
                3'h4: m_reg[m_ptr] = afb - aux_index;
                3'h5: m_reg[m_ptr] = aux_index;
                default: ;
            endcase
            if (load_status_second_instr) {m_ptr, m_buf} = {2{status_buf_value}};
            else if (ptr_load) {m_buf, m_ptr} = {m_ptr, ptr_value};
            else if (load_status_instr) m_ptr = ptr_value;
            if (page_load) m_page = page_value;
        end
        if (chk_on) begin
            #1;
            check(aux_file_bus, m_reg[m_ptr], "aux file bus");
            check(direct_address_bus, {m_page, instr_word[6:0]}, "direct");
            check(data_address_bus, m_dab, "data address");
            check(aux_pointer, m_ptr, "pointer");
            check(aux_pointer_buffer, m_buf, "buffer");
            check(page_pointer, m_page, "page");
            check(data_bus_out, m_dbo, "data bus out");
        end
    end
    // ****************************************************************
    // Stimulus
    // ****************************************************************
    task rand_cycles(input int n);
        repeat (n) begin
            @(posedge aclk);
            c = $urandom % 6;
            ptr_load <= (c == 1);
            load_status_instr <= (c == 2);
            load_status_second_instr <= (c == 3);
            page_load <= (c == 4);
            ptr_value <= 3'($urandom);
            status_buf_value <= 3'($urandom);
            page_value <= 9'($urandom);
            aux_op <= 3'($urandom);
            aux_index <= 16'($urandom);
            instr_word <= 16'($urandom);
            direct_mode <= 1'($urandom);
            data_bus_store <= ($urandom % 4 == 0);
            data_bus_in <= mem_word;
        end
        @(posedge aclk);
        {ptr_load, load_status_instr, load_status_second_instr, page_load} <= 4'h0;
        aux_op <= 3'h0;
        data_bus_store <= 1'b0;
    endtask
    task axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge aclk);
        s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_wdata <= d;
        s_axi_wstrb <= s; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task axi_read(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    initial begin
        void'($urandom(10));
        {instr_word, aux_index, data_bus_in, direct_mode, aux_op, ptr_value} = '0;
        {ptr_load, load_status_instr, load_status_second_instr, page_load} = '0;
        {status_buf_value, page_value, data_bus_store} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk_on = 1;
        rand_cycles(2000);
        chk_on = 0;
        axi_write(8'h08, 32'h0000_1234, 4'h1);
        check(resp, araddr_pkg::RESP_OKAY, "write resp");
        m_reg[2] = 16'h0034;
        axi_read(8'h08);
        check(rd, 32'h0000_0034, "aux read");
        axi_write(8'h20, 32'h0000_0005, 4'h1);
        {m_buf, m_ptr} = {m_ptr, 3'h5};
        axi_read(8'h20);
        check(rd, {21'h0, m_buf, 5'h0, m_ptr}, "pointer read");
        axi_write(8'h24, 32'h0000_01ab, 4'hf);
        m_page = 9'h1ab;
        axi_read(8'h24);
        check(rd, 32'h0000_01ab, "page read");
        axi_read(8'h28);
        check(rd, {16'h0, m_reg[5]}, "view read");
        axi_write(8'h30, 32'h0000_ffff, 4'hf);
        check(resp, araddr_pkg::RESP_SLVERR, "unmapped write");
        axi_read(8'h30);
        check(resp, araddr_pkg::RESP_SLVERR, "unmapped read resp");
        check(rd, 32'h0, "unmapped read data");
        chk_on = 1;
        rand_cycles(500);
        final_report();
    end
endmodule
